// [rtl/core_control_override_bits.v]
// Core control register slice: debounce select and three write-override bits,
// with the interface, GPIO setting and auxiliary converter registers they gate.
// Assumes a decoded host write/read port and DSP-side update strobes on sys_clk.
`timescale 1ns/100ps
`include "core_control_defines.vh"

module core_control_override_bits
#(
    parameter PINS  = 4,
    parameter AUX_W = 12,
    parameter CNT_W = 23
)
(
    input  wire                  sys_clk,
    input  wire                  resetn,
    input  wire                  host_wr,
    input  wire                  host_rd,
    input  wire [11:0]           host_addr,
    input  wire [15:0]           host_wdata,
    output reg  [15:0]           host_rdata,
    input  wire [PINS-1:0]       gpio_pin_in,
    input  wire                  aux_valid,
    input  wire [1:0]            aux_chan,
    input  wire [AUX_W-1:0]      aux_data,
    input  wire                  dsp_wr,
    input  wire [2:0]            dsp_idx,
    input  wire [15:0]           dsp_wdata,
    output reg  [15:0]           control_reg,
    output reg  [PINS-1:0]       gpio_setting,
    output reg  [4*AUX_W-1:0]    aux_regs,
    output reg  [8*16-1:0]       iface_regs
);

wire            aux_ovr   = control_reg[`AUX_OVR_BIT];
wire            gpio_ovr  = control_reg[`GPIO_OVR_BIT];
wire            iface_ovr = control_reg[`IFACE_OVR_BIT];
wire [1:0]      deb_sel   = control_reg[`DEB_SEL_HI:`DEB_SEL_LO];
reg  [CNT_W-1:0] hold_cycles;
wire [PINS-1:0] pin_stable;

// The counts are integers; they are cut to the counter width on purpose.
localparam [31:0] HOLD_00 = `DEB_CYC_00;
localparam [31:0] HOLD_01 = `DEB_CYC_01;
localparam [31:0] HOLD_10 = `DEB_CYC_10;
localparam [31:0] HOLD_11 = `DEB_CYC_11;

function in_range;
    input [11:0] a;
    input [11:0] lo;
    input [11:0] hi;
    begin
        in_range = (a >= lo) && (a <= hi);
    end
endfunction

// ****************************************************************
// Debounce time select
// ****************************************************************
always @*
begin
    case (deb_sel)
        2'b00:   hold_cycles = HOLD_00[CNT_W-1:0];
        2'b01:   hold_cycles = HOLD_01[CNT_W-1:0];
        2'b10:   hold_cycles = HOLD_10[CNT_W-1:0];
        2'b11:   hold_cycles = HOLD_11[CNT_W-1:0];
        default: hold_cycles = HOLD_00[CNT_W-1:0];
    endcase
end

gpio_debounce
#(
    .PINS  (PINS),
    .CNT_W (CNT_W)
)
u_debounce
(
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .pin_in      (gpio_pin_in),
    .hold_cycles (hold_cycles),
    .pin_stable  (pin_stable)
);

// ****************************************************************
// Control register
// ****************************************************************
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
        control_reg <= `CORE_CTRL_RESET;
    else if (host_wr && host_addr == `CORE_CTRL_ADDR)
        control_reg <= host_wdata & `CORE_CTRL_WMASK;
end

// ****************************************************************
// GPIO setting register
// ****************************************************************
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
        gpio_setting <= {PINS{1'b0}};
    else if (gpio_ovr)
    begin
        if (host_wr && host_addr == `GPIO_SET_ADDR)
            gpio_setting <= host_wdata[PINS-1:0];
    end
    else
        gpio_setting <= pin_stable;
end

// ****************************************************************
// Auxiliary converter data registers
// ****************************************************************
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
        aux_regs <= {4*AUX_W{1'b0}};
    else if (aux_ovr)
    begin
        if (host_wr && in_range(host_addr, `AUX_FIRST_ADDR, `AUX_LAST_ADDR))
            aux_regs[(host_addr - `AUX_FIRST_ADDR)*AUX_W +: AUX_W]
                <= host_wdata[AUX_W-1:0];
    end
    else if (aux_valid)
        aux_regs[aux_chan*AUX_W +: AUX_W] <= aux_data;
end

// ****************************************************************
// Interface registers
// ****************************************************************
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
        iface_regs <= {8*16{1'b0}};
    else if (iface_ovr)
    begin
        if (host_wr && in_range(host_addr, `IFACE_FIRST_ADDR, `IFACE_LAST_ADDR))
            iface_regs[host_addr[2:0]*16 +: 16] <= host_wdata;
    end
    else if (dsp_wr)
        iface_regs[dsp_idx*16 +: 16] <= dsp_wdata;
end

// ****************************************************************
// Host read data
// ****************************************************************
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
        host_rdata <= 16'h0000;
    else if (host_rd)
    begin
        if (host_addr == `CORE_CTRL_ADDR)
            host_rdata <= control_reg;
        else if (host_addr == `GPIO_SET_ADDR)
            host_rdata <= {{(16-PINS){1'b0}}, gpio_setting};
        else if (in_range(host_addr, `AUX_FIRST_ADDR, `AUX_LAST_ADDR))
            host_rdata <= {{(16-AUX_W){1'b0}},
                           aux_regs[(host_addr - `AUX_FIRST_ADDR)*AUX_W +: AUX_W]};
        else if (in_range(host_addr, `IFACE_FIRST_ADDR, `IFACE_LAST_ADDR))
            host_rdata <= iface_regs[host_addr[2:0]*16 +: 16];
        else
            host_rdata <= 16'h0000;
    end
end

endmodule // core_control_override_bits

// [rtl/core_control_defines.vh]
// Constants for the core control register and the override-gated register groups.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef CORE_CONTROL_DEFINES_VH
`define CORE_CONTROL_DEFINES_VH

// ****************************************************************
// Register locations
// ****************************************************************
`define CORE_CTRL_ADDR       12'h81C
`define IFACE_FIRST_ADDR     12'h800
`define IFACE_LAST_ADDR      12'h807
`define GPIO_SET_ADDR        12'h808
`define AUX_FIRST_ADDR       12'h809
`define AUX_LAST_ADDR        12'h80C

// ****************************************************************
// Control register fields
// ****************************************************************
`define CORE_CTRL_RESET      16'h0000
`define CORE_CTRL_WMASK      16'h31C0
`define DEB_SEL_HI           13
`define DEB_SEL_LO           12
`define AUX_OVR_BIT          8
`define GPIO_OVR_BIT         7
`define IFACE_OVR_BIT        6

// ****************************************************************
// Debounce timing, times in ms, counts in cycles of 125 MHz
// ****************************************************************
`define CLK_HZ               125000000
`define DEB_MS_00            20
`define DEB_MS_01            40
`define DEB_MS_10            10
`define DEB_MS_11            5
`define DEB_CYC_00           (`CLK_HZ / 1000 * `DEB_MS_00)
`define DEB_CYC_01           (`CLK_HZ / 1000 * `DEB_MS_01)
`define DEB_CYC_10           (`CLK_HZ / 1000 * `DEB_MS_10)
`define DEB_CYC_11           (`CLK_HZ / 1000 * `DEB_MS_11)

`endif

// [rtl/gpio_debounce.v]
// Debouncer for multipurpose pins used as GPIO inputs.
// Assumes pins are asynchronous; the hold time in cycles comes from the caller.
`timescale 1ns/100ps

module gpio_debounce
#(
    parameter PINS  = 4,
    parameter CNT_W = 23
)
(
    input  wire             sys_clk,
    input  wire             resetn,
    input  wire [PINS-1:0]  pin_in,
    input  wire [CNT_W-1:0] hold_cycles,
    output wire [PINS-1:0]  pin_stable
);

// ****************************************************************
// Per-pin three-stage synchroniser and stability counter
// ****************************************************************
genvar g;
generate
    for (g = 0; g < PINS; g = g + 1)
    begin : pin_loop
        reg             sync_a;
        reg             sync_b;
        reg             sync_c;
        reg             level;
        reg [CNT_W-1:0] count;
        always @(posedge sys_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                sync_a <= 1'b0;
                sync_b <= 1'b0;
                sync_c <= 1'b0;
                level  <= 1'b0;
                count  <= {CNT_W{1'b0}};
            end
            else
            begin
                sync_a <= pin_in[g];
                sync_b <= sync_a;
                sync_c <= sync_b;
                // A new level is taken only after it has held for the whole time.
                if (sync_b != sync_c || sync_c == level)
                    count <= {CNT_W{1'b0}};
                else if (count >= hold_cycles - 1'b1)
                begin
                    level <= sync_c;
                    count <= {CNT_W{1'b0}};
                end
                else
                    count <= count + 1'b1;
            end
        end
        assign pin_stable[g] = level;
    end
endgenerate

endmodule // gpio_debounce

// [tb/core_control_properties.sv]
// Port-level assertions for the core control slice.
// Assumes it is bound to core_control_override_bits.
`timescale 1ns/100ps
module core_control_properties
#(parameter PINS = 4, parameter AUX_W = 12)
(input wire sys_clk, resetn, host_wr, dsp_wr,
 input wire [11:0] host_addr, input wire [15:0] host_wdata, dsp_wdata, control_reg,
 input wire [2:0] dsp_idx, input wire [PINS-1:0] gpio_setting,
 input wire [4*AUX_W-1:0] aux_regs, input wire [127:0] iface_regs);
default clocking @(posedge sys_clk); endclocking
default disable iff (!resetn);
a_ctrl_reserved: assert property ((control_reg & 16'hCE3F) == 16'h0000)
    else $error("reserved control bits set");
a_ctrl_write: assert property (host_wr && host_addr == 12'h81C
    |=> control_reg == ($past(host_wdata) & 16'h31C0)) else $error("control write");
a_aux_write: assert property (host_wr && control_reg[8] && host_addr == 12'h809
    |=> aux_regs[AUX_W-1:0] == $past(host_wdata[AUX_W-1:0])) else $error("aux write");
a_gpio_write: assert property (host_wr && control_reg[7] && host_addr == 12'h808
    |=> gpio_setting == $past(host_wdata[PINS-1:0])) else $error("gpio write");
a_iface_write: assert property (host_wr && control_reg[6] && host_addr == 12'h800
    |=> iface_regs[15:0] == $past(host_wdata)) else $error("iface write");
a_aux_hold: assert property (control_reg[8] && !host_wr |=> $stable(aux_regs))
    else $error("aux changed");
a_gpio_hold: assert property (control_reg[7] && !host_wr |=> $stable(gpio_setting))
    else $error("gpio changed");
a_iface_hold: assert property (control_reg[6] && !host_wr |=> $stable(iface_regs))
    else $error("iface changed");
a_dsp_update: assert property (!control_reg[6] && dsp_wr && dsp_idx == 3'h0
    |=> iface_regs[15:0] == $past(dsp_wdata)) else $error("dsp update lost");
endmodule // core_control_properties
bind core_control_override_bits core_control_properties #(.PINS(PINS), .AUX_W(AUX_W))
    u_core_control_properties (.sys_clk(sys_clk), .resetn(resetn), .host_wr(host_wr),
    .dsp_wr(dsp_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .dsp_wdata(dsp_wdata), .control_reg(control_reg), .dsp_idx(dsp_idx),
    .gpio_setting(gpio_setting), .aux_regs(aux_regs), .iface_regs(iface_regs));

// [tb/host_model.sv]
// Host controller on the control port: one-cycle write and read strobes.
// Assumes the bench calls its tasks after reset is released.
`timescale 1ns/100ps
module host_model
(input wire sys_clk, output reg host_wr, host_rd,
 output reg [11:0] host_addr, output reg [15:0] host_wdata);
initial
begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 12'h000;
    host_wdata = 16'h0000;
end
task wr(input [11:0] a, input [15:0] d);
begin
    @(posedge sys_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge sys_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
end
endtask
task rd(input [11:0] a);
begin
    @(posedge sys_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    host_addr <= ~a;
end
endtask
endmodule // host_model

// [tb/core_control_override_bits_tb.sv]
// Self-checking bench: host reads are scored against a queue of expectations.
// Assumes host_model drives the control port.
`timescale 1ns/100ps
module core_control_override_bits_tb;
reg sys_clk, resetn, dsp_wr, aux_valid, noise, rd_d;
reg [3:0] gpio_pin_in;
reg [1:0] aux_chan;
reg [11:0] aux_data;
reg [2:0] dsp_idx;
reg [15:0] dsp_wdata;
reg [15:0] exp_q[$];
reg [15:0] v[0:12];
wire host_wr, host_rd;
wire [11:0] host_addr;
wire [15:0] host_wdata, host_rdata, control_reg;
wire [3:0] gpio_setting;
wire [47:0] aux_regs;
wire [127:0] iface_regs;
integer err_count, comparisons, i;
host_model u_host_model (.sys_clk(sys_clk), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata));
core_control_override_bits u_core_control_override_bits (.sys_clk(sys_clk),
    .resetn(resetn), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .gpio_pin_in(gpio_pin_in),
    .aux_valid(aux_valid), .aux_chan(aux_chan), .aux_data(aux_data), .dsp_wr(dsp_wr),
    .dsp_idx(dsp_idx), .dsp_wdata(dsp_wdata), .control_reg(control_reg),
    .gpio_setting(gpio_setting), .aux_regs(aux_regs), .iface_regs(iface_regs));
initial
begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
end
task check(input [15:0] seen, input [15:0] exp);
begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
end
endtask
task results;
begin
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
end
endtask
task rd_exp(input [11:0] a, input [15:0] e);
begin
    exp_q.push_back(e);
    u_host_model.rd(a);
end
endtask
always @(posedge sys_clk)
begin
    if (rd_d)
        check(host_rdata, exp_q.pop_front());
    rd_d <= host_rd;
end
// Pins, converter and DSP strobes run wild while the overrides are set.
always @(posedge sys_clk)
begin
    if (noise)
    begin
        dsp_wr <= $urandom;
        dsp_idx <= $urandom;
        dsp_wdata <= $urandom;
        aux_valid <= $urandom;
        aux_chan <= $urandom;
        aux_data <= $urandom;
        gpio_pin_in <= $urandom;
    end
end
initial
begin
    repeat (20000) @(posedge sys_clk);
    err_count = err_count + 1;
    results;
end
initial
begin
    err_count = 0;
    comparisons = 0;
    {resetn, dsp_wr, aux_valid, noise, rd_d, gpio_pin_in, aux_chan} = 0;
    {aux_data, dsp_idx, dsp_wdata} = 0;
    i = $urandom(20);
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_exp(12'h81C, 16'h0000);
    rd_exp(12'h81D, 16'h0000);
    for (i = 0; i < 4; i = i + 1)
    begin
        u_host_model.wr(12'h81C, {2'b11, i[1:0], 12'hFFF});
        rd_exp(12'h81C, {2'b00, i[1:0], 12'h1C0});
    end
    noise <= 1'b1;
    for (i = 0; i < 13; i = i + 1)
    begin
        v[i] = $urandom;
        u_host_model.wr(12'h800 + i[3:0], v[i]);
    end
    for (i = 0; i < 13; i = i + 1)
        rd_exp(12'h800 + i[3:0], i < 8 ? v[i] : i == 8 ? {12'h000, v[i][3:0]} :
            {4'h0, v[i][11:0]});
    @(posedge sys_clk) noise <= 1'b0;
    @(posedge sys_clk) {dsp_wr, aux_valid} <= 2'b00;
    u_host_model.wr(12'h81C, 16'h0000);
    u_host_model.wr(12'h800, ~v[0]);
    @(posedge sys_clk);
    {dsp_wr, dsp_idx, dsp_wdata} <= {1'b1, 3'h0, v[1]};
    {aux_valid, aux_chan, aux_data} <= {1'b1, 2'h0, v[2][11:0]};
    @(posedge sys_clk) {dsp_wr, aux_valid} <= 2'b00;
    rd_exp(12'h800, v[1]);
    rd_exp(12'h809, {4'h0, v[2][11:0]});
    gpio_pin_in <= 4'hF;
    repeat (200) @(posedge sys_clk);
    rd_exp(12'h808, 16'h0000);
    repeat (3) @(posedge sys_clk);
    results;
end
endmodule // core_control_override_bits_tb
